// File: design/sledc_defines.svh
`ifndef SLEDC_DEFINES_SVH
`define SLEDC_DEFINES_SVH

// register offsets (byte addresses, one word each)
`define SLEDC_OFF_CTRL 8'h00
`define SLEDC_OFF_PERIOD 8'h04
`define SLEDC_OFF_STATUS 8'h08

// control register fields
`define SLEDC_CTRL_SRC_LSB 0
`define SLEDC_CTRL_SRC_W 2
`define SLEDC_CTRL_PORT_LSB 4
`define SLEDC_CTRL_PORT_W 2
`define SLEDC_CTRL_ADDR_LSB 8
`define SLEDC_CTRL_ADDR_W 8

// reset values
`define SLEDC_CTRL_RST 32'h0000_0000
`define SLEDC_PERIOD_RST 24'h98_9680

// timing: indicator cycle in ms, cycle count derived from 20 MHz clock
`define SLEDC_CYCLE_MS 500
`define SLEDC_CLK_KHZ 20000
`define SLEDC_CYCLE_CLKS (`SLEDC_CYCLE_MS * `SLEDC_CLK_KHZ)

// startup sequence: four half-cycles green, red, green, red
`define SLEDC_STARTUP_STEPS 4
// error blink: cycles of dark gap after a code burst
`define SLEDC_ERR_GAP 3

// data store byte decode
`define SLEDC_VAL_OFF 8'h00
`define SLEDC_VAL_GREEN 8'h01
`define SLEDC_VAL_RED 8'h02
`define SLEDC_VAL_GBLINK 8'h03
`define SLEDC_VAL_RBLINK 8'h04

`endif

// File: design/sledc_pkg.sv
package sledc_pkg;

  typedef enum logic [1:0] {
    SLEDC_SRC_DEFAULT = 2'h0,
    SLEDC_SRC_ACTIVITY = 2'h1,
    SLEDC_SRC_STORE = 2'h2
  } sledc_src_t;

  typedef enum logic [3:0] {
    SLEDC_ST_STARTUP = 4'h1,
    SLEDC_ST_NORMAL = 4'h2,
    SLEDC_ST_ERROR = 4'h4,
    SLEDC_ST_GAP = 4'h8
  } sledc_state_t;

  typedef struct packed {
    logic green;
    logic red;
  } sledc_led_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sledc_bus_t;

endpackage

// File: design/sledc_top.sv
// Summary of operation
// RL1: startup blinks green, red, green, red first
// RL2: error overrides after startup, red blinks give error code
// RL3: default source: steady green without usb
// RL4: default source: blink green with usb
// RL5: tx activity lights green half cycle
// RL6: rx activity lights red half cycle
// RL7: store source follows only stored byte
// RL8: decode byte 0..4, larger values off
// RL9: port select used only in activity source
// RL10: store address used only in store source
// RL11: programmable divider sets cycle, clears activity
`timescale 1ns/1ps
`include "sledc_defines.svh"

module sledc_top #(
  parameter int NUM_PORTS = 4,
  parameter int PERIOD_W = 24,
  parameter logic [23:0] CYCLE_CLKS = 24'(`SLEDC_CYCLE_CLKS / 2)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire sledc_pkg::sledc_bus_t bus,
  output sledc_pkg::sledc_led_t led,
  output logic [31:0] rdata,
  output logic [7:0] store_addr,
  input wire logic [7:0] store_data,
  input wire logic [NUM_PORTS-1:0] tx_strobe,
  input wire logic [NUM_PORTS-1:0] rx_strobe,
  input wire logic usb_connected,
  input wire logic error_flag,
  input wire logic [3:0] error_code
);
  import sledc_pkg::*;

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  if (NUM_PORTS < 1 || NUM_PORTS > 4) begin : g_bad_ports
    $error("NUM_PORTS must be 1 to 4");
  end
  if (PERIOD_W != 24 || CYCLE_CLKS < 24'h2) begin : g_bad_period
    $error("PERIOD_W must be 24 and CYCLE_CLKS at least 2");
  end

  // ------------------------------------------------------------
  // state shared across sections
  // ------------------------------------------------------------
  logic [15:0] ctrl_ff, nxt_ctrl;
  logic [23:0] period_ff, nxt_period;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [7:0] addr_ff, nxt_addr;
  logic act_tx_ff, nxt_act_tx;
  logic act_rx_ff, nxt_act_rx;
  sledc_state_t state_ff, nxt_state;
  sledc_led_t led_ff, nxt_led;
  sledc_src_t src;
  logic [1:0] port_sel;
  logic [7:0] cfg_addr;
  logic [23:0] wr_period;
  logic [31:0] status_word;

  assign src = sledc_src_t'(ctrl_ff[`SLEDC_CTRL_SRC_LSB +: `SLEDC_CTRL_SRC_W]);
  assign port_sel = ctrl_ff[`SLEDC_CTRL_PORT_LSB +: `SLEDC_CTRL_PORT_W];
  assign cfg_addr = ctrl_ff[`SLEDC_CTRL_ADDR_LSB +: `SLEDC_CTRL_ADDR_W];
  assign wr_period = bus.wdata[23:0];

  // status word: state, led, activity, usb, error
  assign status_word = {22'h0, state_ff, led_ff, act_tx_ff, act_rx_ff,
    usb_connected, error_flag};

  // ------------------------------------------------------------
  // register writes and reads
  // ------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_period = period_ff;
    nxt_rdata = 32'h0;
    if (bus.wr) begin
      case (bus.addr)
        `SLEDC_OFF_CTRL: begin
          nxt_ctrl = bus.wdata[15:0];
        end
        `SLEDC_OFF_PERIOD: begin
          // RL11: period floor keeps divider alive
          nxt_period = (wr_period < 24'h2) ? 24'h2 : wr_period;
        end
        default: begin
          nxt_ctrl = ctrl_ff;
        end
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        `SLEDC_OFF_CTRL: begin
          nxt_rdata = {16'h0, ctrl_ff};
        end
        `SLEDC_OFF_PERIOD: begin
          nxt_rdata = {8'h0, period_ff};
        end
        `SLEDC_OFF_STATUS: begin
          nxt_rdata = status_word;
        end
        default: begin
          nxt_rdata = 32'h0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // data store address
  // ------------------------------------------------------------
  always_comb begin
    // RL10: address gated by source
    if (src == SLEDC_SRC_STORE) begin
      nxt_addr = cfg_addr;
    end else begin
      nxt_addr = 8'h0;
    end
  end

  // ------------------------------------------------------------
  // half-cycle divider and activity capture
  // ------------------------------------------------------------
  logic [23:0] div_ff, nxt_div;
  logic half_ff, nxt_half;
  logic show_tx_ff, nxt_show_tx, show_rx_ff, nxt_show_rx;
  logic tick;
  logic port_ok;
  logic tx_sel, rx_sel;

  assign tick = (div_ff == 24'h0);
  // ports beyond NUM_PORTS read as idle
  assign port_ok = 32'(port_sel) < NUM_PORTS;
  // RL9: port chosen only in activity source
  assign tx_sel = (src == SLEDC_SRC_ACTIVITY) && port_ok
    && tx_strobe[port_sel];
  assign rx_sel = (src == SLEDC_SRC_ACTIVITY) && port_ok
    && rx_strobe[port_sel];

  always_comb begin
    // RL11: free-running programmable divider
    nxt_div = tick ? (period_ff - 24'h1) : (div_ff - 24'h1);
    nxt_half = tick ? ~half_ff : half_ff;
    nxt_show_tx = show_tx_ff;
    nxt_show_rx = show_rx_ff;
    nxt_act_tx = act_tx_ff | tx_sel;
    nxt_act_rx = act_rx_ff | rx_sel;
    if (tick && half_ff) begin
      // RL11: latch and clear at cycle boundary
      nxt_show_tx = act_tx_ff | tx_sel;
      nxt_show_rx = act_rx_ff | rx_sel;
      nxt_act_tx = 1'b0;
      nxt_act_rx = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // sequencing state machine
  // ------------------------------------------------------------
  logic [3:0] step_ff, nxt_step;
  logic [3:0] code_ff, nxt_code;
  logic blink;

  // blink phase: lit in first half of cycle
  assign blink = ~half_ff;

  function automatic sledc_led_t sledc_decode(input logic [7:0] v,
                                              input logic ph);
    sledc_led_t r;
    r = '0;
    // RL8: byte decode
    case (v)
      `SLEDC_VAL_OFF: r = '0;
      `SLEDC_VAL_GREEN: r.green = 1'b1;
      `SLEDC_VAL_RED: r.red = 1'b1;
      `SLEDC_VAL_GBLINK: r.green = ph;
      `SLEDC_VAL_RBLINK: r.red = ph;
      default: r = '0;
    endcase
    return r;
  endfunction

  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_code = code_ff;
    nxt_led = '0;
    case (state_ff)
      SLEDC_ST_STARTUP: begin
        // RL1: green, red, green, red sequence
        nxt_led.green = ~step_ff[0];
        nxt_led.red = step_ff[0];
        if (tick) begin
          nxt_step = step_ff + 4'h1;
          if (step_ff == 4'(`SLEDC_STARTUP_STEPS - 1)) begin
            nxt_state = SLEDC_ST_NORMAL;
            nxt_step = 4'h0;
          end
        end
      end
      SLEDC_ST_NORMAL: begin
        case (src)
          SLEDC_SRC_DEFAULT: begin
            // RL3: steady green without usb
            // RL4: blink green with usb
            nxt_led.green = usb_connected ? blink : 1'b1;
          end
          SLEDC_SRC_ACTIVITY: begin
            // RL5: tx green first half
            nxt_led.green = show_tx_ff & ~half_ff;
            // RL6: rx red second half
            nxt_led.red = show_rx_ff & half_ff;
          end
          SLEDC_SRC_STORE: begin
            // RL7: only stored byte drives led
            nxt_led = sledc_decode(store_data, blink);
          end
          default: nxt_led = '0;
        endcase
      end
      SLEDC_ST_ERROR: begin
        // RL2: red blink count equals error code
        nxt_led.red = blink;
        if (tick && half_ff) begin
          nxt_step = step_ff + 4'h1;
          if (step_ff + 4'h1 >= code_ff) begin
            nxt_state = SLEDC_ST_GAP;
            nxt_step = 4'h0;
          end
        end
      end
      SLEDC_ST_GAP: begin
        if (tick && half_ff) begin
          nxt_step = step_ff + 4'h1;
          if (step_ff == 4'(`SLEDC_ERR_GAP - 1)) begin
            nxt_step = 4'h0;
            nxt_state = error_flag ? SLEDC_ST_ERROR : SLEDC_ST_NORMAL;
            nxt_code = (error_code == 4'h0) ? 4'h1 : error_code;
          end
        end
      end
      default: begin
        nxt_state = SLEDC_ST_STARTUP;
        nxt_step = 4'h0;
      end
    endcase
    // RL2: error override after startup
    if (error_flag && state_ff == SLEDC_ST_NORMAL) begin
      nxt_state = SLEDC_ST_ERROR;
      nxt_step = 4'h0;
      nxt_code = (error_code == 4'h0) ? 4'h1 : error_code;
      nxt_led = '0;
    end
  end

  // ------------------------------------------------------------
  // register bank flops
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff <= 16'(`SLEDC_CTRL_RST);
      period_ff <= CYCLE_CLKS;
      rdata_ff <= 32'h0;
      addr_ff <= 8'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      period_ff <= nxt_period;
      rdata_ff <= nxt_rdata;
      addr_ff <= nxt_addr;
    end
  end

  // ------------------------------------------------------------
  // divider and activity flops
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // first startup half lasts a full period too
      div_ff <= CYCLE_CLKS - 24'h1;
      half_ff <= 1'b0;
      act_tx_ff <= 1'b0;
      act_rx_ff <= 1'b0;
      show_tx_ff <= 1'b0;
      show_rx_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      half_ff <= nxt_half;
      act_tx_ff <= nxt_act_tx;
      act_rx_ff <= nxt_act_rx;
      show_tx_ff <= nxt_show_tx;
      show_rx_ff <= nxt_show_rx;
    end
  end

  // ------------------------------------------------------------
  // sequencer flops
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= SLEDC_ST_STARTUP;
      step_ff <= 4'h0;
      code_ff <= 4'h1;
      led_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      code_ff <= nxt_code;
      led_ff <= nxt_led;
    end
  end

  assign led = led_ff;
  assign rdata = rdata_ff;
  assign store_addr = addr_ff;

endmodule

// File: verification/sledc_props.sv
`timescale 1ns/1ps
module sledc_props #(
  parameter logic [23:0] CYCLE_CLKS = 24'h8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire sledc_pkg::sledc_bus_t bus,
  input wire sledc_pkg::sledc_led_t led,
  input wire logic [31:0] rdata,
  input wire logic [7:0] store_addr,
  input wire logic [7:0] store_data,
  input wire logic usb_connected,
  input wire logic error_flag
);
  import sledc_pkg::*;
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic [15:0] up_ff, nxt_up, ctrl_ff, nxt_ctrl;
  logic [7:0] err_ff, nxt_err;
  logic seen_ff, nxt_seen, ready;
  assign ready = 32'(up_ff) > 32'(CYCLE_CLKS) * 32'h4 + 32'h4;
  always_comb begin
    nxt_up = (up_ff == 16'hffff) ? up_ff : up_ff + 16'h1;
    nxt_ctrl = (bus.wr && bus.addr == 8'h00) ? bus.wdata[15:0] : ctrl_ff;
    nxt_err = !error_flag ? 8'h0 : (err_ff == 8'hff) ? err_ff : err_ff + 8'h1;
    nxt_seen = seen_ff | error_flag;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      up_ff <= 16'h0;
      ctrl_ff <= 16'h0;
      err_ff <= 8'h0;
      seen_ff <= 1'b0;
    end else begin
      up_ff <= nxt_up;
      ctrl_ff <= nxt_ctrl;
      err_ff <= nxt_err;
      seen_ff <= nxt_seen;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle_zero:
    assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data not zero without read");
  a_unmapped_zero:
    assert property (bus.rd && bus.addr == 8'h0c |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_store_addr_off:
    assert property ($stable(ctrl_ff) && ctrl_ff[1:0] != 2'h2
      |=> store_addr == 8'h0)
    else $error("store address driven outside store source");
  a_store_addr_on:
    assert property (ctrl_ff[1:0] == 2'h2 && $stable(ctrl_ff)
      ##1 $stable(ctrl_ff) |-> store_addr == ctrl_ff[15:8])
    else $error("store address differs from setting");
  a_store_decode:
    assert property (ready && !seen_ff && !error_flag && ctrl_ff[1:0] == 2'h2
      && $stable(ctrl_ff) && store_data != 8'h3 && store_data != 8'h4
      ##1 $stable(store_data) && $stable(ctrl_ff) && !error_flag |=> led ==
      {$past(store_data, 2) == 8'h01, $past(store_data, 2) == 8'h02})
    else $error("steady store value decoded wrongly");
  a_default_green:
    assert property (ready && !seen_ff && !error_flag && ctrl_ff[1:0] == 2'h0
      && $stable(ctrl_ff) && !usb_connected ##1 !usb_connected
      && $stable(ctrl_ff) && !error_flag |=> led == 2'b10)
    else $error("default source not steady green");
  a_err_no_green:
    assert property (ready && err_ff > 8'h14 |-> !led.green)
    else $error("green lit during error");
  a_startup_lit:
    assert property (up_ff > 16'h2 && 32'(up_ff) < 32'(CYCLE_CLKS) * 32'h4
      |-> led.green != led.red)
    else $error("startup shows dark or both colours");
  a_never_both:
    assert property (led != 2'b11)
    else $error("both colours lit");
endmodule
bind sledc_top sledc_props #(.CYCLE_CLKS(CYCLE_CLKS)) u_props (.clk(clk),
  .rst_n(rst_n), .bus(bus), .led(led), .rdata(rdata),
  .store_addr(store_addr), .store_data(store_data),
  .usb_connected(usb_connected), .error_flag(error_flag));

// File: verification/sledc_store_model.sv
`timescale 1ns/1ps
module sledc_store_model (
  input wire logic [7:0] store_addr,
  output logic [7:0] store_data
);
  // ----------------------------------------
  // byte store seen by the block
  // ----------------------------------------
  logic [7:0] mem [256];
  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'h0;
    end
  end
  assign store_data = mem[store_addr];
endmodule

// File: verification/test_status_led_controller.sv
`timescale 1ns/1ps
module test_status_led_controller;
  import sledc_pkg::*;
  localparam int P = 32'h8;
  logic clk, rst_n, usb, err, pr;
  logic [3:0] code, tx, rx;
  sledc_bus_t bus;
  sledc_led_t led;
  logic [31:0] rdata, v;
  logic [7:0] sa, sd;
  logic [9:0] seq;
  int n_fail, compares, g, r, rise;
  logic [7:0] vals[7] = '{8'h0, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'hff};
  int eg[7] = '{32'h0, 2 * P, 32'h0, P, 32'h0, 32'h0, 32'h0};
  int er[7] = '{32'h0, 32'h0, 2 * P, 32'h0, P, 32'h0, 32'h0};
  sledc_top #(.CYCLE_CLKS(24'(P))) DUT (.clk(clk), .rst_n(rst_n), .bus(bus),
    .led(led), .rdata(rdata), .store_addr(sa), .store_data(sd),
    .tx_strobe(tx), .rx_strobe(rx), .usb_connected(usb), .error_flag(err),
    .error_code(code));
  sledc_store_model STORE (.store_addr(sa), .store_data(sd));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task watch(input int n, input int s);
    repeat (s) @(posedge clk);
    g = 0;
    r = 0;
    rise = 0;
    pr = led.red;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (led.green === 1'b1) g++;
      if (led.red === 1'b1) r++;
      if (led.red === 1'b1 && pr !== 1'b1) rise++;
      pr = led.red;
    end
  endtask
  task close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (32'h2710) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    usb = 1'b0;
    err = 1'b0;
    code = 4'h0;
    tx = 4'h0;
    rx = 4'h0;
    bus = '0;
    seq = 10'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4 * P + 10) begin
      @(posedge clk);
      #1;
      if (led !== seq[1:0] && led != 2'b00) seq = {seq[7:0], led};
    end
    chk("startup order", 32'(seq), 32'h266);
    rd(8'h00);
    chk("ctrl reset", v, 32'h0);
    rd(8'h04);
    chk("period reset", v, 32'(P));
    rd(8'h08);
    chk("status idle", v, 32'h0000_00a0);
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c);
    chk("unmapped read", v, 32'h0);
    watch(2 * P, 0);
    chk("steady green", 32'(g), 32'(2 * P));
    chk("store addr idle", 32'(sa), 32'h0);
    @(posedge clk) usb <= 1'b1;
    watch(2 * P, 4 * P);
    chk("usb blink", 32'(g), 32'(P));
    $display("test default done");
    wr(8'h00, 32'h21);
    @(posedge clk) tx <= 4'h4;
    watch(2 * P, 4 * P);
    chk("tx green", 32'(g), 32'(P));
    chk("tx red", 32'(r), 32'h0);
    @(posedge clk) begin
      tx <= 4'h0;
      rx <= 4'h4;
    end
    watch(2 * P, 4 * P);
    chk("rx red", 32'(r), 32'(P));
    chk("rx green", 32'(g), 32'h0);
    @(posedge clk) begin
      tx <= 4'hb;
      rx <= 4'hb;
    end
    watch(2 * P, 4 * P);
    chk("other port", 32'({g[7:0], r[7:0]}), 32'h0);
    $display("test activity done");
    STORE.mem[8'h00] = 8'h01;
    wr(8'h00, 32'h2a32);
    for (int i = 0; i < 7; i++) begin
      STORE.mem[8'h2a] = vals[i];
      watch(2 * P, 4 * P);
      chk("store green", 32'(g), 32'(eg[i]));
      chk("store red", 32'(r), 32'(er[i]));
    end
    chk("store addr on", 32'(sa), 32'h2a);
    $display("test store done");
    wr(8'h00, 32'h0);
    @(posedge clk) begin
      code <= 4'h3;
      err <= 1'b1;
    end
    watch(12 * P, 0);
    chk("error blinks", 32'(rise), 32'h3);
    wr(8'h04, 32'h1);
    rd(8'h04);
    chk("period floor", v, 32'h2);
    $display("test error done");
    close_out();
  end
endmodule
